// File: hdl/host_port_pkg.sv
// Overview of operation
// - Eight-bit parallel data path joins the host bus directly, no glue logic.
// - Transmit bytes move as one word into the core-side receive word.
// - A 16-bit port control setting selects host bus or GPIO pin function.
// - Non-multiplexed host mode: the eight pins are bidirectional data lines.
// - Multiplexed host mode: the eight pins carry address and data alike.
// - GPIO mode: each pin is input or output by its direction bit.
package host_port_pkg;

	// Core-side register byte addresses.
	localparam logic [7:0] A_PORT_CTRL = 8'h00;
	localparam logic [7:0] A_DIR = 8'h04;
	localparam logic [7:0] A_GPIO = 8'h08;
	localparam logic [7:0] A_CORE_TX = 8'h0C;
	localparam logic [7:0] A_HRX = 8'h10;
	localparam logic [7:0] A_HSTAT = 8'h14;
	localparam logic [7:0] A_IRQ_STAT = 8'h18;
	localparam logic [7:0] A_IRQ_MASK = 8'h1C;

	// Host-side register addresses on the three host address lines.
	localparam logic [2:0] H_STAT = 3'h0;
	localparam logic [2:0] H_VEC = 3'h1;
	localparam logic [2:0] H_HIGH = 3'h5;
	localparam logic [2:0] H_MID = 3'h6;
	localparam logic [2:0] H_LOW = 3'h7;

	// Field positions.
	localparam int B_RECEIVE_DATA_FULL_FLAG = 0;
	localparam int B_TRANSMIT_DATA_EMPTY_FLAG = 1;
	localparam int B_HC = 2;
	localparam int B_HRXF = 3;
	localparam int B_HOST_HC = 7;
	localparam int N_EV = 3;

	// Reset values.
	localparam logic [15:0] RST_PORT_CTRL = 16'h0000;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_VEC = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PM_GPIO = 2'b00,
		PM_NONMUX = 2'b01,
		PM_MUX = 2'b10,
		PM_OFF = 2'b11
	} port_mode_t;

	// Host strobe and address pins, all active low strobes except ale.
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic [2:0] addr;
	} host_ctl_t;

	// Host pins after synchronisation.
	typedef struct packed {
		host_ctl_t ctl;
		logic [7:0] data;
	} host_pins_t;

endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pins; stage one feeds stage two only.
module pin_sync #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// One pair of flops per bit.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				meta[i] <= 1'b1;
				q[i] <= 1'b1;
			end else begin
				meta[i] <= d[i];
				q[i] <= meta[i];
			end
		end
	end
endmodule

// File: hdl/irq_ctrl.sv
`timescale 1ns/1ns
// Sticky event status, write-one-to-clear, with a mask onto one level output.
module irq_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [host_port_pkg::N_EV-1:0] ev,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [host_port_pkg::N_EV-1:0] wr_bits,
	output logic [host_port_pkg::N_EV-1:0] status,
	output logic [host_port_pkg::N_EV-1:0] mask,
	output logic irq
);
	import host_port_pkg::*;

	// A new event wins over a clear arriving in the same cycle.
	for (genvar i = 0; i < N_EV; i++) begin : g_ev
		always_ff @(posedge aclk) begin
			if (!aresetn)
				status[i] <= 1'b0;
			else
				status[i] <= ev[i] | (status[i] & ~(clr_wr & wr_bits[i]));
		end
	end

	// Mask register.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			mask <= '0;
		else if (mask_wr)
			mask <= wr_bits;
	end

	// Output level is registered, so it trails the status by one cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
		ev[0] |=> status[0])
		else $error("event lost against clear");
endmodule

// File: hdl/host_parallel_port.sv
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Byte-wide host port: host pins on one side, AXI4-Lite core side on the other.
module host_parallel_port (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire host_port_pkg::host_ctl_t host_ctl,
	input wire logic [7:0] port_pins_in,
	output logic [7:0] port_pins_out,
	output logic [7:0] port_pins_oe,
	output logic irq
);
	import host_port_pkg::*;

	logic [7:0] aw_addr, ar_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_got, w_got, wr_do, rd_take;
	logic [15:0] port_ctrl;
	logic [7:0] dir, gpio_out, vec, wdat;
	logic [7:0] rx_hi, rx_mid, rx_lo, tx_hi, tx_mid, tx_lo;
	logic [23:0] core_side_receive_word;
	logic receive_data_full_flag, transmit_data_empty_flag, hc, hrx_full, tx_pend;
	logic [2:0] addr_lat, hadr;
	logic [N_EV-1:0] ev, ist, imask;
	logic [31:0] next_rdata;
	logic [7:0] host_rd;
	host_pins_t sy;
	host_ctl_t ctl_q;
	port_mode_t mode;
	logic host_mode, wr_end, rd_end, move;

	// Byte-lane merge for partial writes.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a[7:5] == 3'h0 && a[1:0] == 2'h0;
	endfunction

	// Pins arrive from the host's clock world; nothing reads them raw.
	pin_sync #(.W(15)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({host_ctl, port_pins_in}),
		.q(sy)
	);

	irq_ctrl u_irq (
		.aclk(aclk),
		.aresetn(aresetn),
		.ev(ev),
		.clr_wr(wr_do && aw_addr == A_IRQ_STAT && w_strb[0]),
		.mask_wr(wr_do && aw_addr == A_IRQ_MASK && w_strb[0]),
		.wr_bits(w_data[N_EV-1:0]),
		.status(ist),
		.mask(imask),
		.irq(irq)
	);

	assign wr_do = aw_got && w_got && !s_axi_bvalid;
	assign rd_take = s_axi_arvalid && s_axi_arready;

	// Write address and data are taken independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Core-side read word, decoded from the read address.
	always_comb begin
		next_rdata = '0;
		case (s_axi_araddr)
		A_PORT_CTRL: next_rdata = {16'h0000, port_ctrl};
		A_DIR: next_rdata = {24'h000000, dir};
		A_GPIO: next_rdata = {16'h0000, sy.data, gpio_out};
		A_HRX: next_rdata = {8'h00, core_side_receive_word};
		A_HSTAT: next_rdata = {16'h0000, vec, 4'h0, hrx_full, hc, transmit_data_empty_flag, receive_data_full_flag};
		A_IRQ_STAT: next_rdata = {29'h00000000, ist};
		A_IRQ_MASK: next_rdata = {29'h00000000, imask};
		default: next_rdata = '0;
		endcase
	end

	// Read channel; one read at a time, data one cycle after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			ar_addr <= '0;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			ar_addr <= s_axi_araddr;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Pin configuration registers written by the core.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_ctrl <= RST_PORT_CTRL;
			dir <= RST_DIR;
			gpio_out <= 8'h00;
		end else if (wr_do) begin
			if (aw_addr == A_PORT_CTRL)
				port_ctrl <= 16'(merge({16'h0000, port_ctrl}, w_data,
					w_strb));
			if (aw_addr == A_DIR)
				dir <= 8'(merge({24'h000000, dir}, w_data, w_strb));
			if (aw_addr == A_GPIO)
				gpio_out <= 8'(merge({24'h000000, gpio_out}, w_data,
					w_strb));
		end
	end

	assign mode = port_mode_t'(port_ctrl[1:0]);
	assign host_mode = mode == PM_NONMUX || mode == PM_MUX;
	assign hadr = (mode == PM_MUX) ? addr_lat : sy.ctl.addr;
	assign wr_end = host_mode && !ctl_q.cs_n && !ctl_q.wr_n && sy.ctl.wr_n;
	assign rd_end = host_mode && !ctl_q.cs_n && !ctl_q.rd_n && sy.ctl.rd_n;
	assign move = tx_pend && !hrx_full;

	// Host strobes act on their trailing edge; data is held while writing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= '1;
			wdat <= 8'h00;
			addr_lat <= 3'h0;
		end else begin
			ctl_q <= sy.ctl;
			if (!sy.ctl.wr_n)
				wdat <= sy.data;
			if (mode == PM_MUX && sy.ctl.ale)
				addr_lat <= sy.data[2:0];
		end
	end

	// Core loads the receive bytes; host drains them ending with the low one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			receive_data_full_flag <= 1'b0;
			rx_hi <= 8'h00;
			rx_mid <= 8'h00;
			rx_lo <= 8'h00;
		end else if (wr_do && aw_addr == A_CORE_TX && !receive_data_full_flag) begin
			receive_data_full_flag <= 1'b1;
			{rx_hi, rx_mid, rx_lo} <= 24'(merge({8'h00, rx_hi, rx_mid,
				rx_lo}, w_data, w_strb));
		end else if (rd_end && hadr == H_LOW) begin
			receive_data_full_flag <= 1'b0;
		end
	end

	// Transmit bytes; writes while not empty are dropped by the device.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_hi <= 8'h00;
			tx_mid <= 8'h00;
			tx_lo <= 8'h00;
			tx_pend <= 1'b0;
			transmit_data_empty_flag <= 1'b1;
		end else if (move) begin
			tx_pend <= 1'b0;
			transmit_data_empty_flag <= 1'b1;
		end else if (wr_end && transmit_data_empty_flag) begin
			case (hadr)
			H_HIGH: tx_hi <= wdat;
			H_MID: tx_mid <= wdat;
			H_LOW: begin
				tx_lo <= wdat;
				tx_pend <= 1'b1;
				transmit_data_empty_flag <= 1'b0;
			end
			default: ;
			endcase
		end
	end

	// Completed word moves to the core side; a core read frees it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			core_side_receive_word <= 24'h000000;
			hrx_full <= 1'b0;
		end else if (move) begin
			core_side_receive_word <= {tx_hi, tx_mid, tx_lo};
			hrx_full <= 1'b1;
		end else if (rd_take && s_axi_araddr == A_HRX) begin
			hrx_full <= 1'b0;
		end
	end

	// Host command: the host sets it, the core clears it; setting wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hc <= 1'b0;
			vec <= RST_VEC;
		end else begin
			if (wr_do && aw_addr == A_HSTAT && w_strb[0] && w_data[B_HC])
				hc <= 1'b0;
			if (wr_end && hadr == H_STAT && wdat[B_HOST_HC])
				hc <= 1'b1;
			if (wr_end && hadr == H_VEC && !hc)
				vec <= wdat;
		end
	end

	assign ev[0] = move;
	assign ev[1] = rd_end && hadr == H_LOW && receive_data_full_flag;
	assign ev[2] = wr_end && hadr == H_STAT && wdat[B_HOST_HC] && !hc;

	// Byte returned to the host on a read strobe.
	always_comb begin
		case (hadr)
		H_STAT: host_rd = {hc, 5'h00, transmit_data_empty_flag, receive_data_full_flag};
		H_VEC: host_rd = vec;
		H_HIGH: host_rd = rx_hi;
		H_MID: host_rd = rx_mid;
		H_LOW: host_rd = rx_lo;
		default: host_rd = 8'h00;
		endcase
	end

	// Pin drivers; the host sees data three cycles after its strobe: two to sync, one here.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_pins_out <= 8'h00;
			port_pins_oe <= 8'h00;
		end else if (mode == PM_GPIO) begin
			port_pins_out <= gpio_out;
			port_pins_oe <= dir;
		end else if (host_mode && !sy.ctl.cs_n && !sy.ctl.rd_n &&
			!(mode == PM_MUX && sy.ctl.ale)) begin
			port_pins_out <= host_rd;
			port_pins_oe <= 8'hFF;
		end else begin
			port_pins_out <= 8'h00;
			port_pins_oe <= 8'h00;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_MOVE_WORD: assert property (move |=> core_side_receive_word == $past({tx_hi, tx_mid,
		tx_lo}) && hrx_full)
		else $error("transmit word not moved");
	AST_TRANSMIT_DATA_EMPTY_FLAG_BACK: assert property (move |=> transmit_data_empty_flag && !tx_pend)
		else $error("empty flag not set after move");
	AST_RECEIVE_DATA_FULL_FLAG_CLR: assert property (rd_end && hadr == H_LOW |=> !receive_data_full_flag)
		else $error("full flag not cleared by low read");
	AST_GPIO_DIR: assert property (mode == PM_GPIO ##1 mode == PM_GPIO
		|-> port_pins_oe == $past(dir))
		else $error("gpio direction not applied");
	AST_HOST_OE: assert property (host_mode ##1 |port_pins_oe |->
		$past(!sy.ctl.rd_n && !sy.ctl.cs_n))
		else $error("host pins driven without read strobe");
	AST_BYTE_OUT: assert property (host_mode && !sy.ctl.cs_n &&
		!sy.ctl.rd_n && !sy.ctl.ale |=> port_pins_out == $past(host_rd))
		else $error("host read byte wrong");
	AST_MUX_ADDR: assert property (mode == PM_MUX && sy.ctl.ale |=>
		addr_lat == $past(sy.data[2:0]))
		else $error("multiplexed address not latched");
	AST_VEC_STABLE: assert property (hc && $past(hc) |-> $stable(vec))
		else $error("vector changed during command");
	AST_MODE_OFF: assert property (mode == PM_OFF |=> port_pins_oe == 8'h00)
		else $error("pins driven in off mode");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid)
		else $error("write response dropped");

	COV_MOVE: cover property (move);
	COV_RX_DRAIN: cover property (receive_data_full_flag ##[1:200] !receive_data_full_flag);
	COV_CMD: cover property (ev[2] ##[1:200] !hc);
	COV_MUX_RD: cover property (mode == PM_MUX && |port_pins_oe);
endmodule

// File: dv/host_model.sv
`timescale 1ns/1ns
// Behavioural host processor on the byte-wide pins of the port.
module host_model (
	input wire logic aclk,
	output host_port_pkg::host_ctl_t host_ctl,
	output logic [7:0] port_pins_in,
	input wire logic [7:0] port_pins_out,
	input wire logic [7:0] port_pins_oe
);
	import host_port_pkg::*;
	logic [7:0] drv;
	logic mux;

	// A pin shows the device while it drives, otherwise the host value.
	assign port_pins_in = (port_pins_oe & port_pins_out) |
		(~port_pins_oe & drv);

	// Active-low strobes idle high, ale idles low, and the bus is not multiplexed until told so.
	initial begin
		host_ctl = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0, addr: 3'h0};
		drv = 8'h00;
		mux = 1'b0;
	end

	// Four cycles leave margin over the two the synchronisers need.
	task automatic wait_n(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// In multiplexed mode the address goes out on the pins under ale.
	task automatic start(input logic [2:0] a);
		@(posedge aclk);
		host_ctl.addr <= a;
		if (mux) begin
			drv <= {5'h00, a};
			host_ctl.ale <= 1'b1;
			wait_n(4);
			host_ctl.ale <= 1'b0;
			wait_n(4);
		end
	endtask

	// Released lines show the inverse so a stale byte cannot pass.
	task automatic write(input logic [2:0] a, input logic [7:0] d);
		start(a);
		drv <= d;
		host_ctl.cs_n <= 1'b0;
		host_ctl.wr_n <= 1'b0;
		wait_n(4);
		host_ctl.cs_n <= 1'b1;
		host_ctl.wr_n <= 1'b1;
		wait_n(4);
		drv <= ~d;
	endtask

	// The byte is taken well after the device starts to drive.
	task automatic read(input logic [2:0] a, output logic [7:0] d);
		start(a);
		host_ctl.cs_n <= 1'b0;
		host_ctl.rd_n <= 1'b0;
		wait_n(5);
		d = port_pins_in;
		host_ctl.cs_n <= 1'b1;
		host_ctl.rd_n <= 1'b1;
		wait_n(4);
	endtask
endmodule

// File: dv/host_parallel_port_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
	end \
end

module host_parallel_port_tb;
	import host_port_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq;
	logic [7:0] awaddr, araddr, pin_in, pin_out, pin_oe, hb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rsp;
	host_ctl_t hctl;
	int failures, num_checks, cycles;

	host_parallel_port uut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_ctl(hctl),
		.port_pins_in(pin_in), .port_pins_out(pin_out),
		.port_pins_oe(pin_oe), .irq(irq)
	);

	host_model host (
		.aclk(aclk), .host_ctl(hctl), .port_pins_in(pin_in),
		.port_pins_out(pin_out), .port_pins_oe(pin_oe)
	);

	// Clock of 4 ns.
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// The whole run needs about three hundred cycles, so this only cuts a hang.
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			failures++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Address and data are offered together and each released when taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awready && !aw_ok) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_ok) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
		`CHK(rd, e)
		`CHK(rsp, er)
	endtask

	task automatic hs_chk(input logic [7:0] e);
		host.read(H_STAT, hb);
		`CHK(hb, e)
	endtask

	// High byte first; the low byte completes the word.
	task automatic send_word(input logic [23:0] w);
		for (int i = 0; i < 3; i++) begin
			host.write(3'(H_HIGH + i), w[23 - 8 * i -: 8]);
		end
	endtask

	// Main sequence of scenarios.
	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(A_PORT_CTRL, 32'h0, RESP_OKAY);
		rd_chk(A_HSTAT, 32'h2, RESP_OKAY);
		`CHK(pin_oe, 8'h00)
		axi_wr(A_IRQ_MASK, 32'h7, RESP_OKAY);
		axi_wr(A_PORT_CTRL, 32'h1, RESP_OKAY);
		rd_chk(A_PORT_CTRL, 32'h1, RESP_OKAY);
		// Host to core over the plain data bus.
		hs_chk(8'h02);
		send_word(24'hA1B2C3);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b1)
		rd_chk(A_IRQ_STAT, 32'h1, RESP_OKAY);
		rd_chk(A_HRX, 32'h00A1B2C3, RESP_OKAY);
		hs_chk(8'h02);
		axi_wr(A_IRQ_STAT, 32'h7, RESP_OKAY);
		// Core to host; the low byte read empties the receive bytes.
		axi_wr(A_CORE_TX, 32'h00123456, RESP_OKAY);
		hs_chk(8'h03);
		for (int i = 0; i < 3; i++) begin
			host.read(3'(H_HIGH + i), hb);
			`CHK(hb, 8'h12 + 8'(i * 34))
		end
		`CHK(pin_oe, 8'h00)
		hs_chk(8'h02);
		rd_chk(A_IRQ_STAT, 32'h2, RESP_OKAY);
		axi_wr(A_IRQ_STAT, 32'h7, RESP_OKAY);
		// Vector then command; a vector write under a pending command is lost.
		host.write(H_VEC, 8'h2A);
		host.write(H_STAT, 8'h80);
		rd_chk(A_HSTAT, 32'h2A06, RESP_OKAY);
		host.write(H_VEC, 8'h55);
		rd_chk(A_HSTAT, 32'h2A06, RESP_OKAY);
		`CHK(irq, 1'b1)
		axi_wr(A_IRQ_MASK, 32'h0, RESP_OKAY);
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b0)
		axi_wr(A_HSTAT, 32'h4, RESP_OKAY);
		rd_chk(A_HSTAT, 32'h2A02, RESP_OKAY);
		// Multiplexed bus: address and data share the pins.
		axi_wr(A_PORT_CTRL, 32'h2, RESP_OKAY);
		host.mux = 1'b1;
		send_word(24'h5A6B7C);
		rd_chk(A_HRX, 32'h005A6B7C, RESP_OKAY);
		hs_chk(8'h02);
		host.mux = 1'b0;
		// General-purpose pins: upper nibble out, lower nibble in.
		axi_wr(A_PORT_CTRL, 32'h0, RESP_OKAY);
		axi_wr(A_DIR, 32'hF0, RESP_OKAY);
		axi_wr(A_GPIO, 32'hA5, RESP_OKAY);
		host.drv <= 8'h3C;
		repeat (4) @(posedge aclk);
		`CHK(pin_oe, 8'hF0)
		`CHK(pin_out[7:4], 4'hA)
		rd_chk(A_GPIO, 32'h0000ACA5, RESP_OKAY);
		// Unmapped places answer with an error.
		axi_wr(8'h20, 32'h1, RESP_SLVERR);
		rd_chk(8'h24, 32'h0, RESP_SLVERR);
		finish_test();
	end
endmodule
